// ---- hdl/ldpc_pkg.sv ----
// ldpc_pkg: constants for the led dimming pulse controller.
// assumes a 50 MHz system clock; every timing count derives from it.
`default_nettype none
package ldpc_pkg;
    // clock
    localparam int CLK_HZ = 50000000;
    // dimming pulse width, in microseconds
    localparam int DIM_PULSE_US = 50;
    localparam int DIM_PULSE_CYC = (DIM_PULSE_US * (CLK_HZ / 1000000));
    // repeat interval while the dim button is held, in milliseconds
    localparam int DIM_REPEAT_MS = 400;
    localparam int DIM_REPEAT_CYC = DIM_REPEAT_MS * (CLK_HZ / 1000);
    // pwm frame: 300 hz, i.e. about 3.3 ms
    localparam int PWM_FREQ_HZ = 300;
    localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
    // button debounce time, in milliseconds
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    // number of analog dimming current levels
    localparam int DIM_LEVELS = 32;
    // sensor conversion width
    localparam int SENSOR_BITS = 10;
    // pwm duty width
    localparam int DUTY_BITS = 10;
    // reset value of the host duty setting (full brightness)
    localparam logic [9:0] DUTY_RST = 10'h3FF;
    // sensor gain codes
    localparam logic [1:0] GAIN_PDOWN = 2'h0;
    localparam logic [1:0] GAIN_MEDIUM = 2'h1;
    localparam logic [1:0] GAIN_LOW = 2'h2;
    // top-level operating modes, one-hot
    typedef enum logic [1:0] {
        LDPC_MODE_PWM = 2'b01,
        LDPC_MODE_ANALOG = 2'b10
    } ldpc_mode_type;
endpackage : ldpc_pkg
`default_nettype wire

// ---- hdl/ldpc_debounce.sv ----
// ldpc_debounce: synchronises and debounces one pushbutton.
// assumes an asynchronous active-high button level; emits a clean level and press pulse.
`default_nettype none
module ldpc_debounce #(
    parameter int STABLE_CYC = ldpc_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw button
    input wire logic btn_async,
    // cleaned outputs
    output logic btn_level,
    output logic btn_press
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    initial begin
        if (STABLE_CYC < 1) $error("debounce time must be at least one cycle");
    end

    logic sync1_r; // first stage, read only by sync2_r
    logic sync2_r; // second stage
    logic [CW-1:0] cnt_r; // stability counter
    logic level_r; // accepted level
    logic press_r; // one-cycle press pulse

    // differ flags a candidate level change
    wire differ = (sync2_r != level_r);
    wire settled = (cnt_r == CW'(STABLE_CYC - 1));

    ////////////////////////////////////////////////////////////////////
    // two-flop synchroniser then stability count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r <= '0;
            level_r <= 1'b0;
            press_r <= 1'b0;
        end else begin
            sync1_r <= btn_async;
            sync2_r <= sync1_r;
            // a bounce restarts the count, so one press gives one pulse
            cnt_r <= (differ && !settled) ? cnt_r + CW'(1) : '0;
            press_r <= differ && settled && sync2_r;
            if (differ && settled) begin
                level_r <= sync2_r;
            end
        end
    end

    assign btn_level = level_r;
    assign btn_press = press_r;
endmodule : ldpc_debounce
`default_nettype wire

// ---- hdl/ldpc_top.sv ----
// ldpc_top: led dimming pulse controller, drives the driver's dimming/enable pin.
// assumes host commands are one-cycle pulses on clk; buttons and the
// standalone strap come from pins; sensor samples arrive with a valid pulse on clk.
`default_nettype none
module ldpc_top #(
    parameter int PULSE_CYC = ldpc_pkg::DIM_PULSE_CYC,
    parameter int REPEAT_CYC = ldpc_pkg::DIM_REPEAT_CYC,
    parameter int PERIOD_CYC = ldpc_pkg::PWM_PERIOD_CYC,
    parameter int DEBOUNCE_CYC = ldpc_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pushbuttons and strap, asynchronous pins
    input wire logic enable_toggle_button,
    input wire logic dim_step_button,
    input wire logic standalone_strap,
    // host commands, one-cycle pulses on clk
    input wire logic host_sel_pwm,
    input wire logic host_sel_analog,
    input wire logic host_enable_toggle,
    input wire logic host_dim_press,
    input wire logic host_dim_release,
    input wire logic [9:0] host_duty,
    input wire logic host_sensor_select,
    input wire logic host_sensor_deselect,
    input wire logic [1:0] host_gain,
    input wire logic host_gain_wr,
    // sensor conversion result
    input wire logic [9:0] sensor_sample,
    input wire logic sensor_valid,
    // outputs
    output logic analog_dim_input,
    output logic status_led,
    output logic sensor_power_on,
    output logic [1:0] sensor_gain,
    output logic analog_mode,
    output logic sensor_mode,
    output logic [4:0] dim_level
);
    localparam int PCW = $clog2(PERIOD_CYC + 1);
    localparam int RCW = $clog2(REPEAT_CYC + 1);
    initial begin
        if (PULSE_CYC < 1 || REPEAT_CYC <= PULSE_CYC) $error("bad pulse timing");
        if (PERIOD_CYC < 1024) $error("pwm period too short for 10-bit duty");
    end

    ////////////////////////////////////////////////////////////////////
    // buttons and strap
    logic en_press; // debounced enable press pulse
    logic dim_held; // debounced dim level
    logic dim_btn_press; // debounced dim press pulse
    logic strap1_r; // strap sync stage one
    logic strap_r; // strap synchronised

    ldpc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_en (
        .clk(clk),
        .rst(rst),
        .btn_async(enable_toggle_button),
        .btn_level(),
        .btn_press(en_press)
    );
    ldpc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_dim (
        .clk(clk),
        .rst(rst),
        .btn_async(dim_step_button),
        .btn_level(dim_held),
        .btn_press(dim_btn_press)
    );

    // strap synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap1_r <= 1'b0;
            strap_r <= 1'b0;
        end else begin
            strap1_r <= standalone_strap;
            strap_r <= strap1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode and enable state
    ldpc_pkg::ldpc_mode_type mode_r; // pwm or analog dimming
    ldpc_pkg::ldpc_mode_type mode_nxt;
    logic enabled_r; // driver enabled in analog mode
    logic host_dim_held_r; // host holds its dim key
    logic sensor_sel_r; // sensor control selected
    logic [1:0] gain_r; // sensor gain / power-down
    logic [9:0] duty_r; // host pwm duty
    logic [9:0] sdata_r; // last sensor sample
    logic [4:0] level_r; // current step count

    // standalone forces analog mode; host commands are ignored there
    wire host_ok = !strap_r;
    wire go_analog = strap_r || (host_ok && host_sel_analog);
    wire go_pwm = host_ok && host_sel_pwm && !go_analog;
    wire in_analog = (mode_r == ldpc_pkg::LDPC_MODE_ANALOG);
    wire toggle_cmd = in_analog && (en_press || (host_ok && host_enable_toggle));
    wire enter_analog = go_analog && !in_analog;
    // sensor selection only from pwm mode
    wire sel_sensor = host_ok && host_sensor_select && !in_analog && !go_analog;
    wire drop_sensor = go_analog || strap_r || (host_ok && host_sensor_deselect);
    wire gain_ok = host_gain == ldpc_pkg::GAIN_MEDIUM || host_gain == ldpc_pkg::GAIN_LOW
        || host_gain == ldpc_pkg::GAIN_PDOWN;

    // mode decode
    always_comb begin
        mode_nxt = mode_r;
        if (go_analog) begin
            mode_nxt = ldpc_pkg::LDPC_MODE_ANALOG;
        end else if (go_pwm) begin
            mode_nxt = ldpc_pkg::LDPC_MODE_PWM;
        end
    end

    // mode register; pwm after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= ldpc_pkg::LDPC_MODE_PWM;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // enable toggle; entering analog mode starts disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enabled_r <= 1'b0;
        end else if (enter_analog || !in_analog) begin
            enabled_r <= 1'b0;
        end else if (toggle_cmd) begin
            enabled_r <= !enabled_r;
        end
    end

    // host settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            duty_r <= ldpc_pkg::DUTY_RST;
            sensor_sel_r <= 1'b0;
            gain_r <= ldpc_pkg::GAIN_PDOWN;
            sdata_r <= '0;
            host_dim_held_r <= 1'b0;
        end else begin
            if (host_ok) begin
                duty_r <= host_duty;
            end
            if (drop_sensor) begin
                sensor_sel_r <= 1'b0;
                gain_r <= ldpc_pkg::GAIN_PDOWN;
            end else if (sel_sensor) begin
                sensor_sel_r <= 1'b1;
                gain_r <= ldpc_pkg::GAIN_PDOWN;
            end else if (sensor_sel_r && host_gain_wr && gain_ok) begin
                gain_r <= host_gain;
            end
            if (sensor_valid) begin
                sdata_r <= sensor_sample;
            end
            if (!host_ok || host_dim_release || !in_analog) begin
                host_dim_held_r <= 1'b0;
            end else if (host_dim_press) begin
                host_dim_held_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dimming pulse engine
    logic [RCW-1:0] rep_r; // cycles since last pulse start
    logic pulsing_r; // a pulse train is active
    wire dim_start = in_analog && enabled_r
        && (dim_btn_press || (host_ok && host_dim_press && !host_dim_held_r));
    wire dim_hold = in_analog && enabled_r && (dim_held || host_dim_held_r);
    wire rep_end = (rep_r == RCW'(REPEAT_CYC - 1));
    // pin dips low for the pulse width then the rising edge makes the step
    wire in_pulse = pulsing_r && (rep_r < RCW'(PULSE_CYC));
    wire pulse_rise = pulsing_r && (rep_r == RCW'(PULSE_CYC - 1));

    // one pulse per press, repeated each interval while held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulsing_r <= 1'b0;
            rep_r <= '0;
        end else if (!(in_analog && enabled_r)) begin
            pulsing_r <= 1'b0;
            rep_r <= '0;
        end else if (!pulsing_r) begin
            pulsing_r <= dim_start;
            rep_r <= '0;
        end else if (rep_end) begin
            pulsing_r <= dim_hold;
            rep_r <= '0;
        end else begin
            rep_r <= rep_r + RCW'(1);
        end
    end

    // level counter mirrors the driver's 32 steps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_r <= '0;
        end else if (!enabled_r) begin
            level_r <= '0;
        end else if (pulse_rise) begin
            level_r <= level_r + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pwm generator
    logic [PCW-1:0] pcnt_r; // position in the pwm frame
    wire frame_end = (pcnt_r == PCW'(PERIOD_CYC - 1));
    wire [9:0] duty_sel = sensor_sel_r ? sdata_r : duty_r;
    // high time scales the 10-bit duty onto the frame; period never changes
    wire [PCW+9:0] high_prod = (PCW+10)'(duty_sel) * (PCW+10)'(PERIOD_CYC);
    wire [PCW-1:0] high_cyc = PCW'(high_prod >> 10);
    wire sensor_dark = sensor_sel_r && (gain_r == ldpc_pkg::GAIN_PDOWN);
    wire pwm_level = !sensor_dark && ((pcnt_r < high_cyc) || duty_sel == 10'h3FF);

    // free-running frame counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcnt_r <= '0;
        end else begin
            pcnt_r <= frame_end ? '0 : pcnt_r + PCW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output registers
    wire pin_nxt = in_analog ? (enabled_r && !in_pulse) : pwm_level;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_dim_input <= 1'b0;
            status_led <= 1'b0;
            sensor_power_on <= 1'b0;
            sensor_gain <= ldpc_pkg::GAIN_PDOWN;
            analog_mode <= 1'b0;
            sensor_mode <= 1'b0;
            dim_level <= '0;
        end else begin
            analog_dim_input <= pin_nxt;
            status_led <= in_analog && enabled_r;
            sensor_power_on <= sensor_sel_r && gain_r != ldpc_pkg::GAIN_PDOWN;
            sensor_gain <= gain_r;
            analog_mode <= in_analog;
            sensor_mode <= sensor_sel_r;
            dim_level <= level_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    // helper: cycles the pin has stayed low; saturates so long pwm lows cannot wrap
    logic [RCW-1:0] low_run_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_run_r <= '0;
        end else if (analog_dim_input) begin
            low_run_r <= '0;
        end else if (low_run_r != '1) begin
            low_run_r <= low_run_r + RCW'(1);
        end
    end

    a_pwm_default: assert property (@(posedge clk) disable iff (rst)
        (!strap_r && !host_sel_analog && !in_analog) |=> !in_analog)
        else $error("left pwm mode without analog select");
    a_analog_entry_low: assert property (@(posedge clk) disable iff (rst)
        enter_analog |=> ##1 !analog_dim_input)
        else $error("pin not low on analog mode entry");
    a_enable_high: assert property (@(posedge clk) disable iff (rst)
        (in_analog && !enabled_r && toggle_cmd && !go_pwm)
        |=> ##1 (analog_dim_input && status_led))
        else $error("enable did not raise pin and indicator");
    // a pwm select in the same cycle hands the pin back to the pwm generator
    a_disable_low: assert property (@(posedge clk) disable iff (rst)
        (in_analog && enabled_r && toggle_cmd && !go_pwm)
        |=> ##1 (!analog_dim_input && !status_led))
        else $error("disable did not drop pin");
    // every low dip while enabled must last exactly the pulse width
    a_pulse_width: assert property (@(posedge clk) disable iff (rst)
        (analog_mode && status_led && $past(status_led) && $rose(analog_dim_input))
        |-> low_run_r == RCW'(PULSE_CYC))
        else $error("dimming pulse width wrong");
    a_pulse_rise: assert property (@(posedge clk) disable iff (rst)
        (pulse_rise && enabled_r && in_analog) |=> level_r == $past(level_r) + 5'h01)
        else $error("level not stepped at pulse end");
    a_frame_wrap: assert property (@(posedge clk) disable iff (rst)
        frame_end |=> pcnt_r == '0)
        else $error("pwm frame did not wrap");
    a_sensor_pwm_only: assert property (@(posedge clk) disable iff (rst)
        $rose(sensor_sel_r)
        |-> ($past(mode_r) == ldpc_pkg::LDPC_MODE_PWM && gain_r == ldpc_pkg::GAIN_PDOWN))
        else $error("sensor selected outside pwm mode");
    a_standalone: assert property (@(posedge clk) disable iff (rst)
        strap_r |=> !sensor_sel_r)
        else $error("sensor active in standalone");
    a_sensor_dark: assert property (@(posedge clk) disable iff (rst)
        (sensor_sel_r && gain_r == ldpc_pkg::GAIN_PDOWN) |=> !sensor_power_on)
        else $error("sensor powered before gain chosen");
endmodule : ldpc_top
`default_nettype wire

// ---- dv/ldpc_driver_model.sv ----
// ldpc_driver_model: behavioural led driver watching the dimming/enable pin.
// assumes the pin is sampled on clk; a low longer than shut_cyc shuts it down.
`default_nettype none
module ldpc_driver_model #(
    parameter int SHUT_CYC = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin from the controller
    input wire logic dim_pin,
    // observed driver state
    output logic lit,
    output logic [4:0] step_count
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    logic prev_r; // pin level one cycle ago
    int low_cnt; // cycles the pin has stayed low

    // short lows are dimming steps; a long low is a shutdown
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lit <= 1'b0;
            step_count <= 5'h00;
            prev_r <= 1'b0;
            low_cnt <= 0;
        end else begin
            prev_r <= dim_pin;
            if (!dim_pin) begin
                if (low_cnt < SHUT_CYC) begin
                    low_cnt <= low_cnt + 1;
                end else begin
                    // held low: dark, current level forgotten
                    lit <= 1'b0;
                    step_count <= 5'h00;
                end
            end else begin
                low_cnt <= 0;
                if (!prev_r && lit) begin
                    step_count <= step_count + 5'h01;
                end else if (!prev_r) begin
                    // wake-up edge starts at full scale
                    lit <= 1'b1;
                end
            end
        end
    end
endmodule : ldpc_driver_model
`default_nettype wire

// ---- dv/ldpc_top_test.sv ----
// ldpc_top_test: self-checking bench for the dimming pulse controller.
// assumes shortened counts below; all inputs change on falling clock edges.
`default_nettype none
module ldpc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    localparam int PULSE = 4;
    localparam int REPEAT = 40;
    localparam int PERIOD = 1030; // not a power of two, so period slips show
    localparam int DEB = 3;
    localparam int LIMIT = 40000;
    // stimulus
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] cmd = 9'h000; // one host strobe per bit
    logic en_btn = 1'b0;
    logic dim_btn = 1'b0;
    logic strap = 1'b0;
    logic [9:0] duty = 10'h3FF;
    logic [1:0] gain = 2'h0;
    logic [9:0] sample = 10'h000;
    // observed
    logic pin, led, spow, smode, amode, lit;
    logic [1:0] sgain;
    logic [4:0] level, steps;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int lows;

    ldpc_top #(.PULSE_CYC(PULSE), .REPEAT_CYC(REPEAT), .PERIOD_CYC(PERIOD),
        .DEBOUNCE_CYC(DEB)) u_dut (
        .clk(clk), .rst(rst), .enable_toggle_button(en_btn),
        .dim_step_button(dim_btn), .standalone_strap(strap),
        .host_sel_pwm(cmd[0]), .host_sel_analog(cmd[1]),
        .host_enable_toggle(cmd[2]), .host_dim_press(cmd[3]),
        .host_dim_release(cmd[4]), .host_duty(duty),
        .host_sensor_select(cmd[5]), .host_sensor_deselect(cmd[6]),
        .host_gain(gain), .host_gain_wr(cmd[7]), .sensor_sample(sample),
        .sensor_valid(cmd[8]), .analog_dim_input(pin), .status_led(led),
        .sensor_power_on(spow), .sensor_gain(sgain), .analog_mode(amode),
        .sensor_mode(smode), .dim_level(level));

    ldpc_driver_model u_drv (.clk(clk), .rst(rst), .dim_pin(pin), .lit(lit),
        .step_count(steps));

    ////////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n

    // one-cycle host strobe, then let the two-edge answer land
    task automatic pulse(input int b);
        @(negedge clk);
        cmd[b] = 1'b1;
        @(negedge clk);
        cmd = 9'h000;
        wait_n(2);
    endtask : pulse

    task automatic count_low(input int n);
        lows = 0;
        repeat (n) begin
            @(negedge clk);
            if (pin === 1'b0) lows++;
        end
    endtask : count_low

    // skip a whole frame so a new duty has taken hold, then measure one
    task automatic frame_low();
        wait_n(PERIOD + 4);
        count_low(PERIOD);
    endtask : frame_low

    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    initial begin
        wait_n(3);
        rst = 1'b0;
        wait_n(4);
        chk(32'(amode), 32'h0);
        count_low(PERIOD);
        chk(lows, 0);
        // two duty splits of one fixed frame
        for (int i = 0; i < 2; i++) begin
            duty = (i == 0) ? 10'h200 : 10'h080;
            frame_low();
            chk(lows, PERIOD - int'(duty) * PERIOD / 1024);
        end
        // sensor path: selected powered down, then medium gain
        pulse(5);
        chk({30'h0, smode, spow}, 32'h2);
        chk(32'(sgain), 32'(ldpc_pkg::GAIN_PDOWN));
        frame_low();
        chk(lows, PERIOD);
        gain = ldpc_pkg::GAIN_MEDIUM;
        pulse(7);
        chk({29'h0, spow, sgain}, 32'h5);
        sample = 10'h100;
        pulse(8);
        frame_low();
        chk(lows, PERIOD - 256 * PERIOD / 1024);
        gain = 2'h3;
        pulse(7);
        chk(32'(sgain), 32'h1);
        gain = ldpc_pkg::GAIN_LOW;
        pulse(7);
        chk({29'h0, spow, sgain}, 32'h6);
        pulse(6);
        // analog dimming: pin low until enabled
        pulse(1);
        chk({29'h0, amode, led, pin}, 32'h4);
        // a shutdown-length low, so the enable edge wakes the driver whatever the pwm phase
        wait_n(12);
        chk(32'(lit), 32'h0);
        pulse(5);
        chk(32'(smode), 32'h0);
        pulse(2);
        chk({30'h0, led, pin}, 32'h3);
        wait_n(4);
        chk({26'h0, lit, steps}, 32'h20);
        // short host press: exactly one pulse
        fork
            begin
                pulse(3);
                pulse(4);
            end
            count_low(60);
        join
        chk(lows, PULSE);
        chk({22'h0, level, steps}, 32'h21);
        // held press repeats, release stops it
        fork
            pulse(3);
            count_low(100);
        join
        chk(lows, 3 * PULSE);
        fork
            pulse(4);
            count_low(100);
        join
        chk(lows, 0);
        chk(32'(level), 32'h4);
        // bouncy physical press still gives one pulse
        fork
            begin
                dim_btn = 1'b1;
                wait_n(1);
                dim_btn = 1'b0;
                wait_n(1);
                dim_btn = 1'b1;
                wait_n(DEB + 10);
                dim_btn = 1'b0;
            end
            count_low(80);
        join
        chk(lows, PULSE);
        // 27 more steps bring 5 round to level 0
        for (int i = 0; i < 27; i++) begin
            pulse(3);
            pulse(4);
            wait_n(REPEAT);
        end
        chk(32'(level), 32'h0);
        // disable from the physical toggle button
        en_btn = 1'b1;
        wait_n(DEB + 8);
        en_btn = 1'b0;
        wait_n(20);
        chk({30'h0, led, pin}, 32'h0);
        chk(32'(lit), 32'h0);
        pulse(0);
        chk(32'(amode), 32'h0);
        // strap forces analog mode and locks out the host
        strap = 1'b1;
        wait_n(8);
        pulse(0);
        pulse(5);
        chk({29'h0, amode, smode, spow}, 32'h4);
        end_sim();
    end
endmodule : ldpc_top_test
`default_nettype wire
